/* File: pkg/fopc_pkg.sv */
package fopc_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_KEY = 8'h04;
    localparam logic [7:0] OFS_SEL = 8'h08;
    localparam logic [7:0] OFS_TGT = 8'h0C;
    localparam logic [7:0] OFS_FREQ = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    // field positions
    localparam int BIT_DL_REQ = 0;
    localparam int BIT_SEL_PROG = 0;
    localparam int BIT_SEL_ERASE = 1;
    localparam int BIT_TGT_ERR = 7;
    localparam int BIT_RES_SEL = 2;
    localparam int BIT_RES_KEY = 1;
    // key and marker values
    localparam logic [7:0] KEY_DOWNLOAD = 8'hA5;
    localparam logic [7:0] KEY_CLEAR = 8'h00;
    localparam logic [7:0] RESULT_OK = 8'h00;
    localparam logic [31:0] PROG_END_ADDR = 32'hFFFFFFFF;
    localparam logic [7:0] ERASE_END_BLK = 8'hFF;
    localparam logic [7:0] FREQ_MIN_MHZ = 8'h05;
    localparam logic [7:0] FREQ_MAX_MHZ = 8'h21;
    localparam int CHUNK_BYTES = 128;
    localparam int CHUNK_ADDR_BITS = 7;
    // boot host commands
    typedef enum logic [2:0] {
        FOPC_CMD_NONE = 3'h0,
        FOPC_CMD_PROG_PREP = 3'h1,
        FOPC_CMD_ERASE_PREP = 3'h2,
        FOPC_CMD_PROG = 3'h3,
        FOPC_CMD_ERASE = 3'h4,
        FOPC_CMD_DATA = 3'h5,
        FOPC_CMD_READ = 3'h6
    } fopc_cmd_t;
    // boot sequencer states
    typedef enum logic [6:0] {
        BT_INQUIRY = 7'b0000001,
        BT_ERASE_ALL = 7'b0000010,
        BT_CMD_WAIT = 7'b0000100,
        BT_PROG_WAIT = 7'b0001000,
        BT_PROG_DATA = 7'b0010000,
        BT_ERASE_WAIT = 7'b0100000,
        BT_USER = 7'b1000000
    } fopc_boot_t;
    // download sequencer states
    typedef enum logic [5:0] {
        DL_IDLE = 6'b000001,
        DL_MAP = 6'b000010,
        DL_CHECK = 6'b000100,
        DL_COPY = 6'b001000,
        DL_RESULT = 6'b010000,
        DL_UNMAP = 6'b100000
    } fopc_dl_t;
endpackage : fopc_pkg

/* File: test/fopc_chk_assertions.sv */
`timescale 1ns/10ps
module fopc_chk #(
    parameter int DL_LEN = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic user_mode_i,
    input wire logic cmd_valid_i,
    input wire fopc_pkg::fopc_cmd_t cmd_code_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic erase_all_o,
    input wire logic prog_byte_we_o,
    input wire logic erase_blk_o,
    input wire logic [7:0] erase_blk_num_o,
    input wire logic boot_array_wp_o,
    input wire logic map_store_o,
    input wire logic ram_we_o,
    input wire logic irq_hold_o,
    input wire logic cpu_hold_o
);
    import fopc_pkg::*;
    localparam int DL_MAX = 2 * DL_LEN + 20;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // download keeps cpu and interrupts held and ends in bounded time; control register reads zero
    map_holds_a: assert property ($rose(map_store_o) |-> irq_hold_o && cpu_hold_o)
        else $error("store mapped without holds");
    ram_in_dl_a: assert property (ram_we_o |-> cpu_hold_o)
        else $error("ram write outside download");
    hold_len_a: assert property ($rose(irq_hold_o) |-> ##[1:DL_MAX] !irq_hold_o)
        else $error("download does not end");
    ctrl_zero_a: assert property (
        reg_rd_i && reg_addr_i == OFS_CTRL |=> reg_rdata_o == 8'h00)
        else $error("request bit read as one");
    // boot command side effects need their cause
    erase_quiet_a: assert property (erase_all_o |-> !(prog_byte_we_o || erase_blk_o))
        else $error("write during full erase");
    byte_cause_a: assert property (
        prog_byte_we_o |-> $past(cmd_valid_i && cmd_code_i == FOPC_CMD_DATA))
        else $error("byte write without data command");
    blk_cause_a: assert property (
        erase_blk_o |-> $past(cmd_valid_i && cmd_code_i == FOPC_CMD_ERASE)
        && erase_blk_num_o != ERASE_END_BLK)
        else $error("bad block erase");
    user_wp_a: assert property (user_mode_i && $past(user_mode_i) |-> boot_array_wp_o)
        else $error("boot array open in user mode");
    // main scenarios
    cover property ($rose(map_store_o));
    cover property (erase_blk_o);
    cover property (prog_byte_we_o);
endmodule : fopc_chk

bind fopc_top fopc_chk #(.DL_LEN(DL_LEN)) u_chk (
    .clk_sys_i, .rst_b_i, .user_mode_i, .cmd_valid_i, .cmd_code_i, .reg_addr_i, .reg_rd_i,
    .reg_rdata_o, .erase_all_o, .prog_byte_we_o, .erase_blk_o, .erase_blk_num_o,
    .boot_array_wp_o, .map_store_o, .ram_we_o, .irq_hold_o, .cpu_hold_o
);

/* File: test/fopc_store_model.sv */
`timescale 1ns/10ps
module fopc_store_model #(
    parameter int ERASE_CYC = 20,
    parameter logic [7:0] STORE_XOR = 8'h3C
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic erase_all_i,
    input wire logic map_store_i,
    input wire logic [11:0] store_addr_i,
    output logic [7:0] store_data_o,
    output logic erase_all_done_o
);
    logic [7:0] cnt_ff;
    logic [7:0] junk_ff;
    // erase engine timer and a bus pattern that moves every cycle
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_ff <= 8'h00;
            junk_ff <= 8'h00;
        end
        else
        begin
            cnt_ff <= erase_all_i ? cnt_ff + 8'h01 : 8'h00;
            junk_ff <= junk_ff + 8'h35;
        end
    end
    // full erase of both arrays completes after a fixed time
    assign erase_all_done_o = erase_all_i && cnt_ff == 8'(ERASE_CYC);
    // store answers only while mapped in place of the user array
    assign store_data_o = map_store_i ? store_addr_i[7:0] ^ STORE_XOR : junk_ff;
endmodule : fopc_store_model

/* File: test/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import fopc_pkg::*;
    localparam int DL_LEN = 16;
    localparam int SLOTS = 4;
    localparam logic [7:0] SX = 8'h3C;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, user_mode_i = 1'b0, inquiry_done_i = 1'b0;
    logic cmd_valid_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, exec_in_ram_i = 1'b0;
    fopc_cmd_t cmd_code_i = FOPC_CMD_NONE;
    logic [31:0] cmd_arg_i = 32'h0, prog_addr_o, rng = 32'hAF0B;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, b;
    logic erase_all_done_i, erase_all_o, read_grant_o, read_refuse_o, prog_byte_we_o, ram_we_o;
    logic prog_chunk_o, erase_blk_o, boot_array_wp_o, map_store_o, irq_hold_o, cpu_hold_o;
    logic [7:0] store_data_i, reg_rdata_o, prog_byte_o, erase_blk_num_o, ram_wdata_o;
    logic [11:0] store_addr_o, ram_addr_o;
    logic rd_d = 1'b0;
    logic [63:0] e;
    logic [63:0] expq [6][$];
    logic [7:0] fq [4] = '{8'h04, 8'h05, 8'h21, 8'h22};
    string kn [6] = '{"byte", "chunk", "block", "read", "ram", "reg"};
    int mismatches = 0, total_checks = 0, cycles = 0, n;
    wire [5:0] ev = {rd_d, ram_we_o, read_grant_o | read_refuse_o, erase_blk_o, prog_chunk_o,
        prog_byte_we_o};

    fopc_top #(.DL_LEN(DL_LEN), .TGT_SLOTS(SLOTS), .RAM_AW(12)) dut (
        .clk_sys_i, .rst_b_i, .user_mode_i, .inquiry_done_i, .erase_all_done_i, .cmd_valid_i,
        .cmd_code_i, .cmd_arg_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .exec_in_ram_i, .store_data_i, .reg_rdata_o, .erase_all_o, .read_grant_o,
        .read_refuse_o, .prog_byte_we_o, .prog_byte_o, .prog_chunk_o, .prog_addr_o,
        .erase_blk_o, .erase_blk_num_o, .boot_array_wp_o, .map_store_o, .store_addr_o,
        .ram_we_o, .ram_addr_o, .ram_wdata_o, .irq_hold_o, .cpu_hold_o
    );
    fopc_store_model #(.ERASE_CYC(20), .STORE_XOR(SX)) u_store (
        .clk_sys_i, .rst_b_i, .erase_all_i(erase_all_o), .map_store_i(map_store_o),
        .store_addr_i(store_addr_o), .store_data_o(store_data_i),
        .erase_all_done_o(erase_all_done_i)
    );

    // clock and helpers
    always #5 clk_sys_i = ~clk_sys_i;
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd
    function automatic logic [31:0] seen(input int k);
        case (k)
            0: return {24'h0, prog_byte_o};
            1: return prog_addr_o;
            2: return {24'h0, erase_blk_num_o};
            3: return {30'h0, read_refuse_o, read_grant_o};
            4: return {12'h0, ram_addr_o, ram_wdata_o};
            default: return {24'h0, reg_rdata_o};
        endcase
    endfunction : seen
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, x, s);
        end
    endtask : check
    task automatic note(input int k, input logic [31:0] x);
        expq[k].push_back({32'hFFFF_FFFF, x});
    endtask : note
    task automatic do_reset(input logic um);
        rst_b_i <= 1'b0;
        user_mode_i <= um;
        repeat (16) @(posedge clk_sys_i); // only pulled outside program or erase
        rst_b_i <= 1'b1;
    endtask : do_reset
    // register bus and boot command strobes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
        expq[5].push_back({24'h0, m, 24'h0, x});
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
    endtask : rd
    task automatic cmd(input fopc_cmd_t c, input logic [31:0] a);
        @(posedge clk_sys_i);
        cmd_code_i <= c;
        cmd_arg_i <= a;
        cmd_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        cmd_valid_i <= 1'b0;
    endtask : cmd
    // one download request with its expected ram writes
    task automatic dl(input logic [7:0] sel, input logic [7:0] slot, input logic [7:0] res);
        int base;
        base = int'(slot) * (DL_LEN + 1);
        wr(OFS_SEL, sel);
        wr(OFS_TGT, slot);
        wr(OFS_KEY, KEY_DOWNLOAD);
        for (int i = 1; i <= DL_LEN && res == RESULT_OK && slot < SLOTS; i++)
            note(4, 32'((base + i) << 8) | 32'(8'(i - 1) ^ SX));
        if (slot < SLOTS)
            note(4, 32'(base << 8) | 32'(res));
        // caller keeps stack and a non-FF result preset; no other master on flash
        exec_in_ram_i <= 1'b1;
        wr(OFS_CTRL, 8'h01);
        exec_in_ram_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rd(OFS_CTRL, 8'hFF, 8'h00);
        for (n = 0; n < 200 && (irq_hold_o || map_store_o); n++) @(posedge clk_sys_i);
        wr(OFS_KEY, KEY_CLEAR);
        rd(OFS_TGT, 8'h80, slot < SLOTS ? 8'h00 : 8'h80);
    endtask : dl
    task automatic end_sim();
        for (int k = 0; k < 6; k++) mismatches += expq[k].size();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // each result pulse takes the oldest note of its kind; also the run limit
    always @(posedge clk_sys_i)
    begin
        rd_d <= reg_rd_i;
        cycles <= cycles + 1;
        for (int k = 0; k < 6; k++)
        begin
            if (rst_b_i && ev[k] && expq[k].size() == 0)
                check(kn[k], seen(k), ~seen(k));
            else if (rst_b_i && ev[k])
            begin
                e = expq[k].pop_front();
                check(kn[k], seen(k) & e[63:32], e[31:0]);
            end
        end
        if (cycles == 20000)
        begin
            mismatches++;
            end_sim();
        end
    end

    // boot mode then user program mode
    initial
    begin
        do_reset(1'b0);
        inquiry_done_i <= 1'b1;
        note(3, 32'h2);
        cmd(FOPC_CMD_READ, 32'h0);
        for (n = 0; n < 200 && !erase_all_o; n++) @(posedge clk_sys_i);
        for (n = 0; n < 200 && erase_all_o; n++) @(posedge clk_sys_i);
        rd(OFS_STAT, 8'h04, 8'h04);
        note(3, 32'h1);
        cmd(FOPC_CMD_READ, 32'h0);
        cmd(FOPC_CMD_PROG_PREP, 32'h0);
        cmd(FOPC_CMD_PROG, 32'h0000_0180);
        note(1, 32'h0000_0180);
        for (int i = 0; i < CHUNK_BYTES; i++)
        begin
            b = 8'(rnd());
            note(0, {24'h0, b});
            cmd(FOPC_CMD_DATA, {24'h0, b});
        end
        cmd(FOPC_CMD_PROG, PROG_END_ADDR);
        note(3, 32'h1);
        cmd(FOPC_CMD_READ, 32'h0);
        cmd(FOPC_CMD_ERASE_PREP, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            b = 8'(rnd()) & 8'h0F;
            note(2, {24'h0, b});
            cmd(FOPC_CMD_ERASE, {24'h0, b});
        end
        cmd(FOPC_CMD_ERASE, {24'h0, ERASE_END_BLK});
        note(3, 32'h1);
        cmd(FOPC_CMD_READ, 32'h0);
        repeat (2) @(posedge clk_sys_i); // let the last read answer reach the watcher
        do_reset(1'b1);
        cmd(FOPC_CMD_ERASE_PREP, 32'h0);
        cmd(FOPC_CMD_ERASE, 32'h1);
        check("wp", {31'h0, boot_array_wp_o}, 32'h1);
        wr(OFS_SEL, 8'h01);
        for (int j = 0; j < 2; j++)
        begin
            wr(OFS_KEY, j == 0 ? KEY_DOWNLOAD : 8'(rnd()) & 8'hFE);
            exec_in_ram_i <= (j == 1);
            wr(OFS_CTRL, 8'h01);
            exec_in_ram_i <= 1'b0;
            repeat (4) @(posedge clk_sys_i);
            check("hold", {31'h0, irq_hold_o}, 32'h0);
            rd(OFS_STAT, 8'h08, 8'h00);
        end
        dl(8'h01, 8'h01, RESULT_OK);
        dl(8'h02, 8'(SLOTS - 1), RESULT_OK);
        dl(8'h03, 8'h02, 8'h04);
        dl(8'h00, 8'h00, 8'h04);
        dl(8'h01, 8'(SLOTS), RESULT_OK);
        foreach (fq[i])
        begin
            wr(OFS_FREQ, fq[i]);
            b = (fq[i] >= FREQ_MIN_MHZ && fq[i] <= FREQ_MAX_MHZ) ? 8'h01 : 8'h02;
            rd(OFS_STAT, 8'h03, b);
        end
        wr(8'h20, 8'(rnd()));
        rd(8'h20, 8'hFF, 8'h00);
        repeat (3) @(posedge clk_sys_i);
        end_sim();
    end
endmodule : testbench

/* File: verilog/fopc_top.sv */
// Summary of operation
// - after inquiry both memory arrays are erased before any program or erase command
// - program preparation enters program-data wait; host sends command, address, data
// - all-ones start address leaves program-data wait back to command wait
// - erase preparation enters erase-block wait; each erase command carries a block
// - block number FF returns from erase-block wait to command wait
// - boot reads are granted only after the automatic full erase
// - user program mode keeps the boot array write protected
// - each program operation writes exactly one 128-byte unit
// - more than one selected program skips download and flags selection error
// - request bit sets only with key A5 and a write from on-chip RAM
// - request starts download and reads back zero once control returns
// - download maps store, checks, copies, clears request, writes result, unmaps
// - during download interrupts are held and CPU state is frozen
// - result byte 00 at target start means download succeeded
// - result bit 2 is selection fault, bit 1 key fault; target fault sets target register bit 7 and writes no result
// - initialization rejects cpu frequency outside 5 to 33 MHz
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/10ps
module fopc_top #(
    parameter int DL_LEN = 16,
    parameter int TGT_SLOTS = 4,
    parameter int RAM_AW = 12
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic user_mode_i,
    input wire logic inquiry_done_i,
    input wire logic erase_all_done_i,
    input wire logic cmd_valid_i,
    input wire fopc_pkg::fopc_cmd_t cmd_code_i,
    input wire logic [31:0] cmd_arg_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic exec_in_ram_i,
    input wire logic [7:0] store_data_i,
    output logic [7:0] reg_rdata_o,
    output logic erase_all_o,
    output logic read_grant_o,
    output logic read_refuse_o,
    output logic prog_byte_we_o,
    output logic [7:0] prog_byte_o,
    output logic prog_chunk_o,
    output logic [31:0] prog_addr_o,
    output logic erase_blk_o,
    output logic [7:0] erase_blk_num_o,
    output logic boot_array_wp_o,
    output logic map_store_o,
    output logic [RAM_AW-1:0] store_addr_o,
    output logic ram_we_o,
    output logic [RAM_AW-1:0] ram_addr_o,
    output logic [7:0] ram_wdata_o,
    output logic irq_hold_o,
    output logic cpu_hold_o
);
    import fopc_pkg::*;

    localparam int SLOT_BYTES = DL_LEN + 1;
    localparam int CW = $clog2(CHUNK_BYTES + 1);
    localparam int DW = $clog2(DL_LEN + 2);

    fopc_boot_t boot_ff, nxt_boot;
    fopc_dl_t dl_ff, nxt_dl;
    logic [CW-1:0] chunk_cnt_ff;
    logic [DW-1:0] dl_cnt_ff;
    logic [7:0] key_ff;
    logic [1:0] sel_ff;
    logic [6:0] tgt_idx_ff;
    logic tgt_err_ff;
    logic [7:0] freq_ff;
    logic init_ok_ff;
    logic init_err_ff;
    logic dl_req_ff;
    logic arrays_erased_ff;
    logic [7:0] result_ff;

    // register decode
    wire wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
    wire wr_key = reg_wr_i && (reg_addr_i == OFS_KEY);
    wire wr_sel = reg_wr_i && (reg_addr_i == OFS_SEL);
    wire wr_tgt = reg_wr_i && (reg_addr_i == OFS_TGT);
    wire wr_freq = reg_wr_i && (reg_addr_i == OFS_FREQ);
    wire dl_busy = (dl_ff != DL_IDLE);

    // request accepted only with the key and from on-chip RAM
    wire req_ok = wr_ctrl && reg_wdata_i[BIT_DL_REQ] && (key_ff == KEY_DOWNLOAD)
                  && exec_in_ram_i && user_mode_i && !dl_busy;

    // download checks
    wire sel_multi = (sel_ff[BIT_SEL_PROG] && sel_ff[BIT_SEL_ERASE]);
    wire sel_none = (sel_ff == 2'b00);
    wire key_bad = (key_ff != KEY_DOWNLOAD);
    wire tgt_bad = (32'(tgt_idx_ff) >= 32'(TGT_SLOTS));
    wire [RAM_AW-1:0] tgt_base = RAM_AW'(32'(tgt_idx_ff) * SLOT_BYTES);
    wire copy_last = (32'(dl_cnt_ff) == 32'(DL_LEN));

    // frequency range check for initialization
    wire freq_in_range = (reg_wdata_i >= FREQ_MIN_MHZ) && (reg_wdata_i <= FREQ_MAX_MHZ);

    // boot command decode
    wire cmd_prog_end = (cmd_code_i == FOPC_CMD_PROG) && (cmd_arg_i == PROG_END_ADDR);
    wire cmd_erase_end = (cmd_code_i == FOPC_CMD_ERASE) && (cmd_arg_i[7:0] == ERASE_END_BLK);
    wire chunk_full = (32'(chunk_cnt_ff) == 32'(CHUNK_BYTES - 1));
    wire data_in = cmd_valid_i && (cmd_code_i == FOPC_CMD_DATA);

    // read-back mux; request bit always reads zero
    logic [7:0] rd_mux;
    always_comb
    begin
        case (reg_addr_i)
            OFS_CTRL: rd_mux = 8'h00;
            OFS_KEY: rd_mux = key_ff;
            OFS_SEL: rd_mux = {6'h00, sel_ff};
            OFS_TGT: rd_mux = {tgt_err_ff, tgt_idx_ff};
            OFS_FREQ: rd_mux = freq_ff;
            OFS_STAT: rd_mux = {4'h0, dl_busy, arrays_erased_ff, init_err_ff, init_ok_ff};
            default: rd_mux = 8'h00;
        endcase
    end

    // boot sequencer next state
    always_comb
    begin
        nxt_boot = boot_ff;
        case (boot_ff)
            BT_INQUIRY:
                if (user_mode_i)
                    nxt_boot = BT_USER;
                else if (inquiry_done_i)
                    nxt_boot = BT_ERASE_ALL;
            BT_ERASE_ALL:
                if (erase_all_done_i)
                    nxt_boot = BT_CMD_WAIT;
            BT_CMD_WAIT:
                if (cmd_valid_i && cmd_code_i == FOPC_CMD_PROG_PREP)
                    nxt_boot = BT_PROG_WAIT;
                else if (cmd_valid_i && cmd_code_i == FOPC_CMD_ERASE_PREP)
                    nxt_boot = BT_ERASE_WAIT;
            BT_PROG_WAIT:
                if (cmd_valid_i && cmd_prog_end)
                    nxt_boot = BT_CMD_WAIT;
                else if (cmd_valid_i && cmd_code_i == FOPC_CMD_PROG)
                    nxt_boot = BT_PROG_DATA;
            BT_PROG_DATA:
                if (data_in && chunk_full)
                    nxt_boot = BT_PROG_WAIT;
            BT_ERASE_WAIT:
                if (cmd_valid_i && cmd_erase_end)
                    nxt_boot = BT_CMD_WAIT;
            BT_USER:
                nxt_boot = BT_USER;
            default:
                nxt_boot = BT_INQUIRY;
        endcase
    end

    // download sequencer next state
    always_comb
    begin
        nxt_dl = dl_ff;
        case (dl_ff)
            DL_IDLE:
                if (dl_req_ff)
                    nxt_dl = DL_MAP;
            DL_MAP:
                nxt_dl = DL_CHECK;
            DL_CHECK:
                if (tgt_bad)
                    nxt_dl = DL_UNMAP;
                else if (sel_multi || sel_none || key_bad)
                    nxt_dl = DL_RESULT;
                else
                    nxt_dl = DL_COPY;
            DL_COPY:
                if (copy_last)
                    nxt_dl = DL_RESULT;
            DL_RESULT:
                nxt_dl = DL_UNMAP;
            DL_UNMAP:
                nxt_dl = DL_IDLE;
            default:
                nxt_dl = DL_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            boot_ff <= BT_INQUIRY;
            dl_ff <= DL_IDLE;
        end
        else
        begin
            boot_ff <= nxt_boot;
            dl_ff <= nxt_dl;
        end
    end

    // software registers
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            key_ff <= KEY_CLEAR;
            sel_ff <= 2'b00;
            tgt_idx_ff <= 7'h00;
            freq_ff <= 8'h00;
            init_ok_ff <= 1'b0;
            init_err_ff <= 1'b0;
        end
        else
        begin
            if (wr_key)
                key_ff <= reg_wdata_i; // cleared by caller afterwards
            if (wr_sel)
                sel_ff <= reg_wdata_i[1:0];
            if (wr_tgt)
                tgt_idx_ff <= reg_wdata_i[6:0];
            if (wr_freq)
            begin
                freq_ff <= reg_wdata_i;
                init_ok_ff <= freq_in_range;
                init_err_ff <= !freq_in_range;
            end
        end
    end

    // request bit, target fault flag and result byte
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            dl_req_ff <= 1'b0;
            tgt_err_ff <= 1'b0;
            result_ff <= RESULT_OK;
        end
        else
        begin
            if (req_ok)
                dl_req_ff <= 1'b1;
            else if (dl_ff == DL_RESULT || (dl_ff == DL_CHECK && tgt_bad))
                dl_req_ff <= 1'b0;
            if (dl_ff == DL_CHECK)
            begin
                tgt_err_ff <= tgt_bad;
                result_ff <= RESULT_OK;
                result_ff[BIT_RES_SEL] <= sel_multi || sel_none;
                result_ff[BIT_RES_KEY] <= key_bad;
            end
        end
    end

    // copy counter and store mapping
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            dl_cnt_ff <= '0;
            map_store_o <= 1'b0;
            store_addr_o <= '0;
        end
        else
        begin
            dl_cnt_ff <= (dl_ff == DL_COPY) ? dl_cnt_ff + 1'b1 : '0;
            map_store_o <= (nxt_dl != DL_IDLE) && (nxt_dl != DL_UNMAP);
            store_addr_o <= (nxt_dl == DL_COPY) ? RAM_AW'(dl_cnt_ff) : '0;
        end
    end

    // RAM writes: program bytes after the result slot, result at slot start
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ram_we_o <= 1'b0;
            ram_addr_o <= '0;
            ram_wdata_o <= 8'h00;
        end
        else if (dl_ff == DL_COPY && dl_cnt_ff != '0)
        begin
            ram_we_o <= 1'b1;
            ram_addr_o <= tgt_base + RAM_AW'(dl_cnt_ff);
            ram_wdata_o <= store_data_i;
        end
        else if (dl_ff == DL_RESULT)
        begin
            ram_we_o <= 1'b1;
            ram_addr_o <= tgt_base;
            ram_wdata_o <= result_ff;
        end
        else
        begin
            ram_we_o <= 1'b0;
            ram_addr_o <= '0;
            ram_wdata_o <= 8'h00;
        end
    end

    // interrupt and CPU hold across the whole download
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            irq_hold_o <= 1'b0;
            cpu_hold_o <= 1'b0;
        end
        else
        begin
            irq_hold_o <= req_ok || dl_req_ff || (nxt_dl != DL_IDLE);
            cpu_hold_o <= req_ok || dl_req_ff || (nxt_dl != DL_IDLE);
        end
    end

    // boot chunk assembly and erase requests
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            chunk_cnt_ff <= '0;
            arrays_erased_ff <= 1'b0;
            erase_all_o <= 1'b0;
            prog_byte_we_o <= 1'b0;
            prog_byte_o <= 8'h00;
            prog_chunk_o <= 1'b0;
            prog_addr_o <= 32'h00000000;
            erase_blk_o <= 1'b0;
            erase_blk_num_o <= 8'h00;
            read_grant_o <= 1'b0;
            read_refuse_o <= 1'b0;
            boot_array_wp_o <= 1'b1;
        end
        else
        begin
            erase_all_o <= (nxt_boot == BT_ERASE_ALL);
            if (boot_ff == BT_ERASE_ALL && erase_all_done_i)
                arrays_erased_ff <= 1'b1;
            if (boot_ff == BT_PROG_WAIT && cmd_valid_i && cmd_code_i == FOPC_CMD_PROG
                && !cmd_prog_end)
                prog_addr_o <= {cmd_arg_i[31:CHUNK_ADDR_BITS], {CHUNK_ADDR_BITS{1'b0}}};
            if (boot_ff == BT_PROG_DATA && data_in)
                chunk_cnt_ff <= chunk_full ? '0 : chunk_cnt_ff + 1'b1;
            prog_byte_we_o <= (boot_ff == BT_PROG_DATA) && data_in;
            prog_byte_o <= cmd_arg_i[7:0];
            prog_chunk_o <= (boot_ff == BT_PROG_DATA) && data_in && chunk_full;
            erase_blk_o <= (boot_ff == BT_ERASE_WAIT) && cmd_valid_i
                           && (cmd_code_i == FOPC_CMD_ERASE) && !cmd_erase_end;
            erase_blk_num_o <= cmd_arg_i[7:0];
            read_grant_o <= (boot_ff == BT_CMD_WAIT) && cmd_valid_i
                            && (cmd_code_i == FOPC_CMD_READ) && arrays_erased_ff;
            read_refuse_o <= cmd_valid_i && (cmd_code_i == FOPC_CMD_READ)
                             && !((boot_ff == BT_CMD_WAIT) && arrays_erased_ff);
            boot_array_wp_o <= user_mode_i || (boot_ff != BT_CMD_WAIT
                               && boot_ff != BT_PROG_WAIT && boot_ff != BT_PROG_DATA
                               && boot_ff != BT_ERASE_WAIT);
        end
    end

    // registered read data
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            reg_rdata_o <= 8'h00;
        else
            reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end

endmodule : fopc_top
